/* File: pkg/hub_port_power_pkg.sv */
package hub_port_power_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CHARGE_PORT_ENABLE_OFS  = 8'hd0;
    localparam logic [7:0] PORT_POWER_STATUS_OFS   = 8'he5;
    localparam logic [7:0] OVERCURRENT_CONTROL_OFS = 8'he6;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         DATA_W                  = 8;
    localparam int         PORTS_DEF               = 3;
    localparam int         FIRST_PORT_BIT          = 1;
    localparam int         PIN_PORT                = 3;
    localparam logic [7:0] CHARGE_PORT_ENABLE_RST  = 8'h00;
    localparam logic [7:0] PORT_POWER_STATUS_RST   = 8'h00;
    localparam logic [7:0] OVERCURRENT_CONTROL_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VAL       = 8'h00;
    localparam logic       SENSE_PIN_IDLE          = 1'b1;

    // ------------------------------------------------------------
    // Register access request from the serial port engine
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reg_rsp_t;

endpackage

/* File: src/sense_sync.sv */
`timescale 1ns/1ps

module sense_sync
    import hub_port_power_pkg::*;
#(
    parameter int       WIDTH     = 1,
    parameter bit       RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // First stage is read only by the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= {WIDTH{RESET_VAL}};
            sync_q <= {WIDTH{RESET_VAL}};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

/* File: src/hub_port_power_regs.sv */
// Function
// RULE_01 - Charge enable register: bit N enables port N; bits 7:4 and 0 reserved.
// RULE_02 - Charge enable bit zero disables charging support, one enables it.
// RULE_03 - Port power status bits 3:1 are read-only; writes leave them unchanged.
// RULE_04 - Status reads one when host powered port, zero if not or over-current.
// RULE_05 - Actual port power comes from host request, over-current and charging logic.
// RULE_06 - Software never writes one to over-current register bits 7:4.
// RULE_07 - With pin select one, port 3 register bit ignored; sense pin used.
// RULE_08 - With pin select zero, port 3 register bit is port 3 over-current.
// RULE_09 - Over-current register bits 2:1 are over-current for ports 2 and 1.
// RULE_10 - Setting an effective over-current bit clears that port's power status.
// RULE_11 - Over-current bit zero means no condition, one means over-current.
// RULE_12 - Pin select one uses active-low sense pin; zero uses register control.
// RULE_13 - All three registers are zero after reset.
`timescale 1ns/1ps

module hub_port_power_regs
    import hub_port_power_pkg::*;
#(
    parameter int PORTS = PORTS_DEF
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // Register access from serial port engine
    input  wire reg_req_t       reg_req,
    output reg_rsp_t            reg_rsp,
    // Hub core, same clock
    input  wire logic [PORTS:1] host_port_power_req,
    input  wire logic           overcurrent_pin_select,
    // Device pin, asynchronous
    input  wire logic           overcurrent_sense_pin_n,
    // Results toward hub core and port switches
    output logic      [PORTS:1] battery_charge_enable,
    output logic      [PORTS:1] overcurrent_report,
    output logic      [PORTS:1] port_power_on
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // Ports live in bits 7:1; pin-driven port must exist
    if (PORTS < PIN_PORT || PORTS > DATA_W - FIRST_PORT_BIT) begin : g_bad_ports
        $error("PORTS out of range for 8-bit register layout");
    end

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic hit(input reg_req_t req, input logic [7:0] ofs);
        hit = (req.addr == ofs);
    endfunction

    function automatic logic [PORTS:1] port_field(input logic [7:0] v);
        port_field = v[PORTS:FIRST_PORT_BIT];
    endfunction

    function automatic logic [7:0] to_byte(input logic [PORTS:1] f);
        logic [7:0] b;
        b = 8'h00;
        b[PORTS:FIRST_PORT_BIT] = f;
        to_byte = b;
    endfunction

    // ------------------------------------------------------------
    // Sense pin synchroniser
    // ------------------------------------------------------------
    logic sense_pin_n_sync;

    sense_sync #(
        .WIDTH     (1),
        .RESET_VAL (SENSE_PIN_IDLE)
    ) u_sense_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (overcurrent_sense_pin_n),
        .sync_out (sense_pin_n_sync)
    );

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    // Reserved bits are not stored and read back as zero
    logic [PORTS:1] charge_en_q;
    logic [PORTS:1] charge_en_d;
    logic [PORTS:1] oc_flags_q;
    logic [PORTS:1] oc_flags_d;

    always_comb begin
        charge_en_d = charge_en_q;
        oc_flags_d  = oc_flags_q;
        if (reg_req.wr && hit(reg_req, CHARGE_PORT_ENABLE_OFS)) begin
            charge_en_d = port_field(reg_req.wdata); // see RULE_01
        end
        // Upper bits dropped; software is expected to keep them zero
        if (reg_req.wr && hit(reg_req, OVERCURRENT_CONTROL_OFS)) begin
            oc_flags_d = port_field(reg_req.wdata); // see RULE_06
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            charge_en_q <= port_field(CHARGE_PORT_ENABLE_RST); // see RULE_13
            oc_flags_q  <= port_field(OVERCURRENT_CONTROL_RST); // see RULE_13
        end else begin
            charge_en_q <= charge_en_d;
            oc_flags_q  <= oc_flags_d;
        end
    end

    // ------------------------------------------------------------
    // Effective over-current per port
    // ------------------------------------------------------------
    logic [PORTS:1] oc_eff;

    for (genvar p = 1; p <= PORTS; p++) begin : g_oc
        if (p == PIN_PORT) begin : g_pin_port
            // Register bit kept but has no effect while pin selected
            assign oc_eff[p] = overcurrent_pin_select ? ~sense_pin_n_sync // see RULE_07
                                                      : oc_flags_q[p]; // see RULE_08
        end else begin : g_reg_port
            assign oc_eff[p] = oc_flags_q[p]; // see RULE_09
        end
    end

    // ------------------------------------------------------------
    // Port power status and port outputs
    // ------------------------------------------------------------
    logic [PORTS:1] pwr_status_q;
    logic [PORTS:1] pwr_status_d;
    logic [PORTS:1] charge_out_q;
    logic [PORTS:1] charge_out_d;
    logic [PORTS:1] oc_report_q;
    logic [PORTS:1] oc_report_d;
    logic [PORTS:1] power_on_q;
    logic [PORTS:1] power_on_d;

    always_comb begin
        // Status follows hardware only; register writes never reach it
        pwr_status_d = host_port_power_req & ~oc_eff; // see RULE_03 RULE_04 RULE_10
        oc_report_d  = oc_eff; // see RULE_11 RULE_12
        charge_out_d = charge_en_q; // see RULE_02
        // Charging may power a port the host left off; over-current always wins
        power_on_d   = (host_port_power_req | charge_en_q) & ~oc_eff; // see RULE_05
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_status_q <= port_field(PORT_POWER_STATUS_RST); // see RULE_13
            charge_out_q <= port_field(CHARGE_PORT_ENABLE_RST);
            oc_report_q  <= port_field(OVERCURRENT_CONTROL_RST);
            power_on_q   <= port_field(PORT_POWER_STATUS_RST);
        end else begin
            pwr_status_q <= pwr_status_d;
            charge_out_q <= charge_out_d;
            oc_report_q  <= oc_report_d;
            power_on_q   <= power_on_d;
        end
    end

    assign battery_charge_enable = charge_out_q;
    assign overcurrent_report    = oc_report_q;
    assign port_power_on         = power_on_q;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    reg_rsp_t rsp_q;
    reg_rsp_t rsp_d;

    always_comb begin
        rsp_d.valid = reg_req.rd;
        rsp_d.data  = UNMAPPED_READ_VAL;
        if (reg_req.rd) begin
            if (hit(reg_req, CHARGE_PORT_ENABLE_OFS)) begin
                rsp_d.data = to_byte(charge_en_q); // see RULE_01
            end else if (hit(reg_req, PORT_POWER_STATUS_OFS)) begin
                rsp_d.data = to_byte(pwr_status_q); // see RULE_03
            end else if (hit(reg_req, OVERCURRENT_CONTROL_OFS)) begin
                rsp_d.data = to_byte(oc_flags_q);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign reg_rsp = rsp_q;

endmodule

/* File: sim/hub_port_power_regs_chk.sv */
`timescale 1ns/1ps
module hub_port_power_regs_chk
    import hub_port_power_pkg::*;
#(
    parameter int PORTS = PORTS_DEF
) (
    // Clock and reset
    input wire logic           clk,
    input wire logic           rst,
    // Register bus
    input wire reg_req_t       reg_req,
    input wire reg_rsp_t       reg_rsp,
    // Hub side
    input wire logic [PORTS:1] host_port_power_req,
    input wire logic           overcurrent_pin_select,
    input wire logic           overcurrent_sense_pin_n,
    input wire logic [PORTS:1] battery_charge_enable,
    input wire logic [PORTS:1] overcurrent_report,
    input wire logic [PORTS:1] port_power_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_charge_write: assert property (
        (reg_req.wr && reg_req.addr == CHARGE_PORT_ENABLE_OFS) ##2 1'b1
        |-> battery_charge_enable == $past(reg_req.wdata[PORTS:1], 2)) else $error("charge enable");
    a_charge_read: assert property (
        reg_req.rd && reg_req.addr == CHARGE_PORT_ENABLE_OFS |=> reg_rsp.valid
        && reg_rsp.data[PORTS:1] == battery_charge_enable && !reg_rsp.data[0]) else $error("charge read");
    a_status_read: assert property (
        reg_req.rd && reg_req.addr == PORT_POWER_STATUS_OFS && !$past(rst) |=> reg_rsp.valid
        && reg_rsp.data[PORTS:1] == ($past(host_port_power_req, 2) & ~$past(overcurrent_report)))
        else $error("status read");
    a_oc_write: assert property (
        (reg_req.wr && reg_req.addr == OVERCURRENT_CONTROL_OFS && !overcurrent_pin_select)
        ##1 !overcurrent_pin_select |=> overcurrent_report == $past(reg_req.wdata[PORTS:1], 2))
        else $error("oc flags");
    a_pin_overrides: assert property (
        overcurrent_pin_select [*4] |-> overcurrent_report[PIN_PORT]
        == !$past(overcurrent_sense_pin_n, 3)) else $error("sense pin");
    a_power_combine: assert property (
        !$past(rst) |-> port_power_on == (($past(host_port_power_req) | battery_charge_enable)
        & ~overcurrent_report)) else $error("port power");
    a_oc_reserved: assert property (
        reg_req.rd && reg_req.addr == OVERCURRENT_CONTROL_OFS |=> reg_rsp.valid
        && reg_rsp.data[7:4] == 4'h0 && !reg_rsp.data[0]) else $error("oc reserved");
    a_reset_zero: assert property (
        $past(rst) |-> battery_charge_enable == '0 && overcurrent_report == '0
        && !reg_rsp.valid) else $error("reset values");
endmodule

bind hub_port_power_regs hub_port_power_regs_chk #(.PORTS(PORTS)) u_chk (
    .clk(clk), .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .host_port_power_req(host_port_power_req), .overcurrent_pin_select(overcurrent_pin_select),
    .overcurrent_sense_pin_n(overcurrent_sense_pin_n),
    .battery_charge_enable(battery_charge_enable), .overcurrent_report(overcurrent_report),
    .port_power_on(port_power_on));

/* File: sim/soc_host_model.sv */
`timescale 1ns/1ps
module soc_host_model
    import hub_port_power_pkg::*;
(
    // Register bus
    input  wire logic     clk,
    output reg_req_t      reg_req,
    input  wire reg_rsp_t reg_rsp
);
    initial reg_req = '0;

    // Idle bus shows inverted address and data, so stale values never match
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          input int gap, output reg_rsp_t r);
        if (wr && a == OVERCURRENT_CONTROL_OFS) d[7:4] = 4'h0;
        repeat (gap) @(negedge clk);
        @(negedge clk);
        reg_req <= {wr, ~wr, a, d};
        @(negedge clk);
        r = reg_rsp;
        reg_req <= {2'b00, ~a, ~d};
    endtask
endmodule

/* File: sim/test_hub_port_power_regs.sv */
`timescale 1ns/1ps
module test_hub_port_power_regs;
    import hub_port_power_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    reg_req_t    req;
    reg_rsp_t    rsp, r;
    logic [3:1]  host = 3'h0, bce, ocr, pwr;
    logic        sel = 1'b0, pin = 1'b1;
    logic [31:0] seed = 32'h091f540c;
    int          n_errors = 0, compares = 0, cycles = 0, chg, oc, hm, eff;

    always #20 clk = ~clk;

    hub_port_power_regs u_dut (.clk(clk), .rst(rst), .reg_req(req), .reg_rsp(rsp),
        .host_port_power_req(host), .overcurrent_pin_select(sel),
        .overcurrent_sense_pin_n(pin), .battery_charge_enable(bce),
        .overcurrent_report(ocr), .port_power_on(pwr));
    soc_host_model u_soc (.clk(clk), .reg_req(req), .reg_rsp(rsp));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_soc.access(1'b0, a, 8'h00, 0, r);
        check({7'h00, r.valid}, 8'h01, "read valid");
        check(r.data, exp, "read data");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 700 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rd(CHARGE_PORT_ENABLE_OFS, 8'h00);
        rd(PORT_POWER_STATUS_OFS, 8'h00);
        rd(OVERCURRENT_CONTROL_OFS, 8'h00);
        rd(8'h5a, UNMAPPED_READ_VAL);
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(lfsr(seed));
            hm = seed[3:1];
            host = seed[3:1];
            sel = seed[4] & seed[5];
            pin = seed[6];
            chg = seed[11:9];
            oc = seed[19:17];
            u_soc.access(1'b1, CHARGE_PORT_ENABLE_OFS, seed[15:8], 0, r);
            u_soc.access(1'b1, OVERCURRENT_CONTROL_OFS, seed[23:16], i % 3, r);
            u_soc.access(1'b1, PORT_POWER_STATUS_OFS, seed[31:24], 0, r);
            repeat (4) @(negedge clk);
            eff = sel ? ((pin ? 0 : 4) | (oc & 3)) : oc;
            check({5'h00, bce}, 8'(chg), "charge out");
            check({5'h00, ocr}, 8'(eff), "oc report");
            check({5'h00, pwr}, 8'((hm | chg) & ~eff & 7), "power");
            rd(CHARGE_PORT_ENABLE_OFS, 8'(chg << 1));
            rd(PORT_POWER_STATUS_OFS, 8'((hm & ~eff & 7) << 1));
            rd(OVERCURRENT_CONTROL_OFS, 8'(oc << 1));
        end
        $display("random test done");
        end_of_test();
    end
endmodule
